// file: hdl/isf_pkg.sv
// Purpose: shared constants and carriers of the two-wire slave/fifo/ack control block
// Assumes: 32-bit APB, byte offsets below
// Notes: timing unit of the clock-low timeout is one standard bus clock period
package isf_pkg;
   localparam int ISF_PCLK_MHZ = 125;
   localparam int ISF_TO_UNIT_NS = 10000;
   localparam int ISF_TO_UNIT_CYC = (ISF_TO_UNIT_NS * ISF_PCLK_MHZ) / 1000;
   localparam int ISF_FIFO_DEPTH = 8;
   localparam logic [7:0] ISF_OFF_TARGET = 8'h00;
   localparam logic [7:0] ISF_OFF_TIMEOUT = 8'h04;
   localparam logic [7:0] ISF_OFF_LINE = 8'h08;
   localparam logic [7:0] ISF_OFF_RAW = 8'h0C;
   localparam logic [7:0] ISF_OFF_MASK = 8'h10;
   localparam logic [7:0] ISF_OFF_VIEW = 8'h14;
   localparam logic [7:0] ISF_OFF_VIEWSEL = 8'h18;
   localparam logic [7:0] ISF_OFF_OWNADDR = 8'h20;
   localparam logic [7:0] ISF_OFF_SDATA = 8'h24;
   localparam logic [7:0] ISF_OFF_SCTL = 8'h28;
   localparam logic [7:0] ISF_OFF_ACK = 8'h2C;
   localparam logic [7:0] ISF_OFF_RXCFG = 8'h30;
   localparam logic [7:0] ISF_OFF_RXDATA = 8'h34;
   localparam logic [7:0] ISF_OFF_SSTAT = 8'h38;
   // bit positions
   localparam int ISF_INT_TIMEOUT = 0;
   localparam int ISF_INT_RXREQ = 1;
   localparam int ISF_INT_START = 2;
   localparam int ISF_INT_STOP = 3;
   localparam int ISF_INT_W = 4;
   localparam int ISF_OWN_IDX_BIT = 8;
   localparam int ISF_FLUSH_BIT = 8;
   localparam int ISF_ACK_OVR_BIT = 0;
   localparam int ISF_ACK_VAL_BIT = 1;
   localparam int ISF_TO_SHIFT = 4;
   // reset values
   localparam logic [6:0] ISF_OWN0_RST = 7'h00;
   localparam logic [6:0] ISF_OWN1_RST = 7'h00;
   localparam logic [7:0] ISF_TARGET_RST = 8'h00;

   typedef struct packed {
      logic rxfifo_en;
      logic txfifo_en;
      logic slave_en;
   } isf_slv_ctl_s;

   typedef struct packed {
      logic dma;
      logic slave_owner;
      logic [2:0] trig_m1;
   } isf_rx_cfg_s;
endpackage

// file: hdl/isf_ctrl.sv
// Purpose: APB control/status of a two-wire bus controller: slave engine, rx fifo, ack override, timeout
// Assumes: pclk 125 MHz; scl/sda pins sampled through two flip-flops; open-drain sda
// Notes: zero-wait APB answer; master engine proper lives elsewhere
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module isf_ctrl
   import isf_pkg::*;
#(
   parameter int FIFO_DEPTH = ISF_FIFO_DEPTH,
   parameter int TO_UNIT_CYC = ISF_TO_UNIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic fifo_req,
   output logic dma_req,
   output logic master_irq
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int UW = $clog2(TO_UNIT_CYC + 1);
   if (FIFO_DEPTH != 8) begin : g_chk_depth
      $error("isf_ctrl: trigger levels need a depth of exactly 8");
   end
   if (TO_UNIT_CYC < 1) begin : g_chk_unit
      $error("isf_ctrl: timeout unit must be at least one cycle");
   end
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK} isf_state_e;
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus conditions
   logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
         {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
      end else begin
         {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
         {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
      end
   end
   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready_r;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire sel_target = paddr == ISF_OFF_TARGET;
   wire sel_timeout = paddr == ISF_OFF_TIMEOUT;
   wire sel_line = paddr == ISF_OFF_LINE;
   wire sel_raw = paddr == ISF_OFF_RAW;
   wire sel_mask = paddr == ISF_OFF_MASK;
   wire sel_view = paddr == ISF_OFF_VIEW;
   wire sel_viewsel = paddr == ISF_OFF_VIEWSEL;
   wire sel_own = paddr == ISF_OFF_OWNADDR;
   wire sel_sdata = paddr == ISF_OFF_SDATA;
   wire sel_sctl = paddr == ISF_OFF_SCTL;
   wire sel_ack = paddr == ISF_OFF_ACK;
   wire sel_rxcfg = paddr == ISF_OFF_RXCFG;
   wire sel_rxdata = paddr == ISF_OFF_RXDATA;
   wire sel_sstat = paddr == ISF_OFF_SSTAT;
   wire mapped = sel_target | sel_timeout | sel_line | sel_raw | sel_mask | sel_view | sel_viewsel |
                 sel_own | sel_sdata | sel_sctl | sel_ack | sel_rxcfg | sel_rxdata | sel_sstat;
   ////////////////////////////////////////////////////////////////////////////
   // software registers
   logic [7:0] target_r;
   logic [7:0] to_val_r;
   logic to_en_r;
   logic [ISF_INT_W-1:0] raw_r, mask_r;
   logic masked_view_select_r;
   logic [6:0] own0_r, own1_r;
   logic [7:0] tx_data_r, rx_data_r;
   isf_slv_ctl_s slave_control_word_r;
   logic ack_ovr_r, ack_val_r;
   isf_rx_cfg_s rx_cfg_r;
   wire own_address_index = pwdata[ISF_OWN_IDX_BIT];
   wire flush = wr & sel_rxcfg & pwdata[ISF_FLUSH_BIT];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_r <= ISF_TARGET_RST;
         to_val_r <= 8'h00;
         to_en_r <= 1'b0;
         mask_r <= '0;
         masked_view_select_r <= 1'b0;
         own0_r <= ISF_OWN0_RST;
         own1_r <= ISF_OWN1_RST;
         tx_data_r <= 8'h00;
         slave_control_word_r <= '0;
         {ack_val_r, ack_ovr_r} <= 2'h0;
         rx_cfg_r <= '0;
      end else if (wr) begin
         if (sel_target) target_r <= pwdata[7:0];
         if (sel_timeout) begin
            to_val_r <= pwdata[7:0];
            to_en_r <= 1'b1;
         end
         if (sel_mask) mask_r <= pwdata[ISF_INT_W-1:0];
         if (sel_viewsel) masked_view_select_r <= pwdata[0];
         if (sel_own && !own_address_index) own0_r <= pwdata[6:0];
         if (sel_own && own_address_index) own1_r <= pwdata[6:0];
         if (sel_sdata) tx_data_r <= pwdata[7:0];
         if (sel_sctl) slave_control_word_r <= pwdata[2:0];
         if (sel_ack) {ack_val_r, ack_ovr_r} <= {pwdata[ISF_ACK_VAL_BIT], pwdata[ISF_ACK_OVR_BIT]};
         if (sel_rxcfg) rx_cfg_r <= pwdata[4:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // receive fifo
   logic [7:0] fifo_mem [FIFO_DEPTH];
   logic [AW-1:0] wp_r, rp_r;
   logic [AW:0] cnt_r;
   logic rx_push, fifo_req_d_r;
   logic [7:0] shreg_r;
   wire fifo_full = cnt_r == (AW+1)'(FIFO_DEPTH);
   wire fifo_empty = cnt_r == '0;
   // only the slave owner feeds it here; a master-owned fifo is fed by the master engine
   wire rx_to_fifo = slave_control_word_r.rxfifo_en & rx_cfg_r.slave_owner;
   wire push = rx_push & rx_to_fifo & ~fifo_full;
   wire pop = rd & sel_rxdata & ~fifo_empty;
   wire req_level = cnt_r >= {1'b0, rx_cfg_r.trig_m1} + (AW+1)'(1);
   always_ff @(posedge pclk) begin
      if (push) fifo_mem[wp_r] <= shreg_r;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {wp_r, rp_r, cnt_r} <= '0;
      end else if (flush) begin
         {wp_r, rp_r, cnt_r} <= '0;
      end else begin
         wp_r <= wp_r + AW'(push);
         rp_r <= rp_r + AW'(pop);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {fifo_req_d_r, fifo_req, dma_req} <= 3'h0;
      end else begin
         fifo_req_d_r <= fifo_req;
         fifo_req <= req_level;
         dma_req <= req_level & rx_cfg_r.dma;
      end
   end
   wire req_rise = fifo_req & ~fifo_req_d_r;
   ////////////////////////////////////////////////////////////////////////////
   // clock-low timeout, counted in bus clock units
   logic [UW-1:0] unit_r;
   logic [11:0] to_cnt_r;
   wire unit_tick = unit_r == UW'(TO_UNIT_CYC - 1);
   wire [11:0] to_limit = {to_val_r, 4'h0};
   wire to_evt = to_en_r & (to_val_r != 8'h00) & unit_tick & ~scl_s2_r &
                 (to_cnt_r == to_limit - 12'h001);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_r <= '0;
         to_cnt_r <= 12'h000;
      end else if (scl_s2_r) begin
         unit_r <= '0;
         to_cnt_r <= 12'h000;
      end else begin
         unit_r <= unit_tick ? '0 : unit_r + UW'(1);
         if (unit_tick && to_cnt_r != 12'hFFF) to_cnt_r <= to_cnt_r + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master event status; set beats write-one clear
   logic [ISF_INT_W-1:0] evt;
   always_comb begin
      evt = '0;
      evt[ISF_INT_TIMEOUT] = to_evt;
      evt[ISF_INT_RXREQ] = req_rise;
      evt[ISF_INT_START] = start_det;
      evt[ISF_INT_STOP] = stop_det;
   end
   wire [ISF_INT_W-1:0] raw_clr = (wr & sel_raw) ? pwdata[ISF_INT_W-1:0] : '0;
   wire [ISF_INT_W-1:0] masked = raw_r & mask_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_r <= '0;
         master_irq <= 1'b0;
      end else begin
         raw_r <= (raw_r & ~raw_clr) | evt;
         master_irq <= |masked;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave engine
   isf_state_e state_r;
   logic [3:0] bit_r;
   logic rw_r, own2_r, acked_r;
   wire hit1 = shreg_r[7:1] == own0_r;
   wire hit2 = shreg_r[7:1] == own1_r;
   wire addr_hit = slave_control_word_r.slave_en & (hit1 | hit2);
   wire byte_end = scl_fall & (bit_r == 4'h8);
   wire ack_data = ack_ovr_r ? ack_val_r : ~(rx_to_fifo & fifo_full);
   wire ack_addr = ack_ovr_r ? ack_val_r : 1'b1;
   assign rx_push = (state_r == S_RX) & byte_end;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         {bit_r, shreg_r} <= '0;
         {rw_r, own2_r, acked_r, sda_oe} <= 4'h0;
      end else if (stop_det) begin
         state_r <= S_IDLE;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         state_r <= S_ADDR;
         bit_r <= 4'h0;
         sda_oe <= 1'b0;
      end else begin
         unique case (state_r)
            S_IDLE: ;
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  shreg_r <= {shreg_r[6:0], sda_s2_r};
                  bit_r <= bit_r + 4'h1;
               end
               if (byte_end) begin
                  bit_r <= 4'h0;
                  if (state_r == S_RX) begin
                     state_r <= S_RACK;
                     sda_oe <= ack_data;
                  end else if (addr_hit) begin
                     state_r <= S_AACK;
                     sda_oe <= ack_addr;
                     rw_r <= shreg_r[0];
                     own2_r <= hit2 & ~hit1;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
            end
            S_AACK, S_RACK, S_TACK: begin
               if (scl_rise && state_r == S_TACK) begin
                  acked_r <= ~sda_s2_r;
                  if (sda_s2_r) state_r <= S_IDLE;
               end
               if (scl_fall) begin
                  bit_r <= 4'h0;
                  if ((state_r == S_AACK && rw_r) || state_r == S_TACK) begin
                     state_r <= S_TX;
                     shreg_r <= {tx_data_r[6:0], 1'b0};
                     sda_oe <= ~tx_data_r[7];
                  end else begin
                     state_r <= S_RX;
                     sda_oe <= 1'b0;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) bit_r <= bit_r + 4'h1;
               if (byte_end) begin
                  state_r <= S_TACK;
                  sda_oe <= 1'b0;
               end else if (scl_fall) begin
                  sda_oe <= ~shreg_r[7];
                  shreg_r <= {shreg_r[6:0], 1'b0};
               end
            end
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_r <= 8'h00;
         sda_out <= 1'b0;
      end else if (rx_push && !rx_to_fifo) begin
         rx_data_r <= shreg_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux and apb answer
   wire [31:0] rd_word =
      sel_target ? {24'h0, target_r} :
      sel_timeout ? {20'h0, to_val_r, 4'h0} :
      sel_line ? {30'h0, sda_s2_r, scl_s2_r} :
      sel_raw ? {28'h0, raw_r} :
      sel_mask ? {28'h0, mask_r} :
      sel_view ? {28'h0, masked_view_select_r ? masked : raw_r} :
      sel_viewsel ? {31'h0, masked_view_select_r} :
      sel_own ? {17'h0, own1_r, 1'b0, own0_r} :
      sel_sdata ? {24'h0, rx_data_r} :
      sel_ack ? {30'h0, ack_val_r, ack_ovr_r} :
      sel_rxcfg ? {12'h0, 4'(cnt_r), 11'h0, rx_cfg_r} :
      sel_rxdata ? {24'h0, fifo_empty ? 8'h00 : fifo_mem[rp_r]} :
      sel_sstat ? {24'h0, state_r != S_IDLE, own2_r, rw_r, acked_r, fifo_full, slave_control_word_r} :
      32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup) prdata_r <= rd_word;
      end
   end
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   view_select_a: assert property (setup && sel_view && masked_view_select_r && !(wr && sel_raw)
      |=> prdata == {28'h0, $past(raw_r) & $past(mask_r)}) else $error("masked view wrong");
   line_state_a: assert property (setup && sel_line
      |=> prdata[1:0] == {$past(sda_s2_r), $past(scl_s2_r)}) else $error("line readback wrong");
   target_addr_a: assert property (wr && sel_target
      |=> target_r == $past(pwdata[7:0])) else $error("target not loaded");
   timeout_load_a: assert property (wr && sel_timeout
      |=> to_en_r && to_limit == {$past(pwdata[7:0]), 4'h0}) else $error("timeout load wrong");
   timeout_clear_a: assert property (scl_s2_r |=> to_cnt_r == 12'h000) else $error("timeout not cleared");
   fifo_request_a: assert property (req_level |=> fifo_req) else $error("fifo request missing");
   fifo_flush_a: assert property (flush |=> cnt_r == '0 ##1 fifo_req == 1'b0 || cnt_r != '0)
      else $error("flush did not empty");
   ack_override_a: assert property (rx_push && ack_ovr_r && !stop_det && !start_det
      |=> sda_oe == $past(ack_val_r) && state_r == S_RACK) else $error("ack override ignored");
   slave_off_a: assert property ((state_r == S_ADDR) && byte_end && !slave_control_word_r.slave_en
      && !stop_det && !start_det |=> state_r == S_IDLE && !sda_oe) else $error("disabled slave answered");
   ctl_word_a: assert property (wr && sel_sctl
      |=> slave_control_word_r == $past(pwdata[2:0])) else $error("control word not replaced");
endmodule // isf_ctrl
`default_nettype wire

// file: hdl/isf_dummy_unused_guard.sv
`timescale 1ns/100ps

// file: sim/isf_twi_master.sv
// Purpose: behavioural two-wire bus master facing the slave engine
// Assumes: open-drain data line with pull-up; master never stretched
// Notes: scl stands high between frames; 3 ns offset keeps link edges off pclk edges
`timescale 1ns/100ps
`default_nettype none
module isf_twi_master (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   localparam time H = 32;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // data moves only while scl low; sampled mid-high, well after slave turnaround
   task automatic bit_io(input logic b, output logic r);
      #(H/2) sda_pull = !b;
      #(H/2) scl = 1'b1;
      #(H/2) r = sda;
      #(H/2) scl = 1'b0;
   endtask
   task automatic start();
      #3 sda_pull = 1'b0;
      scl = 1'b1;
      #H sda_pull = 1'b1;
      #H scl = 1'b0;
   endtask
   task automatic stop();
      #(H/2) sda_pull = 1'b1;
      #(H/2) scl = 1'b1;
      #H sda_pull = 1'b0;
      #H;
   endtask
   task automatic hold_low(input int ns);
      #3 scl = 1'b0;
      #(ns) scl = 1'b1;
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd(input logic nak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nak, r);
   endtask
endmodule // isf_twi_master
`default_nettype wire

// file: sim/tb_i2c_slave_fifo_ack_control.sv
// Purpose: self-checking bench of the two-wire slave/fifo/ack control block
// Assumes: zero-wait APB slave; timeout unit shortened to 4 pclk
// Notes: read expectations queue up; a watcher compares at each completed read
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_slave_fifo_ack_control
   import isf_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sda_out, sda_oe, fifo_req, dma_req, master_irq, scl, m_pull, ack;
   logic [6:0] a0, a1;
   logic [7:0] d, got, first;
   logic [32:0] q_exp[$];
   logic [32:0] q_msk[$];
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   // open-drain data line with pull-up
   wire sda = (sda_oe ? sda_out : 1'b1) & !m_pull;

   isf_ctrl #(.FIFO_DEPTH(8), .TO_UNIT_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .fifo_req(fifo_req), .dma_req(dma_req), .master_irq(master_irq));
   isf_twi_master m (.scl(scl), .sda_pull(m_pull), .sda(sda));

   always #4 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmp(input logic [32:0] g, input logic [32:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] k = 33'h1_FFFF_FFFF);
      q_exp.push_back(e & k);
      q_msk.push_back(k);
      apb(1'b0, a, 32'h0);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         cmp({pslverr, prdata} & q_msk.pop_front(), q_exp.pop_front());
      end
   end
   task automatic frame(input logic [6:0] a, input logic rw, input logic e);
      m.start();
      m.wr({a, rw}, ack);
      cmp(33'(ack), 33'(e));
   endtask
   task automatic bw(input logic [7:0] v, input logic e);
      m.wr(v, ack);
      cmp(33'(ack), 33'(e));
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(59));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(ISF_OFF_TARGET, 33'h0);
      rd(ISF_OFF_LINE, 33'h3);
      rd(8'h3C, 33'h1_0000_0000);
      d = 8'($urandom);
      wr(ISF_OFF_TARGET, {24'h0, d});
      rd(ISF_OFF_TARGET, {25'h0, d});
      wr(ISF_OFF_TIMEOUT, {24'h0, d});
      rd(ISF_OFF_TIMEOUT, {21'h0, d, 4'h0});
      // value 1 means 16 units of 4 pclk; hold low well past it
      wr(ISF_OFF_TIMEOUT, 32'h1);
      wr(ISF_OFF_RAW, 32'hF);
      fork
         m.hold_low(800);
         begin
            repeat (20) @(posedge pclk);
            rd(ISF_OFF_LINE, 33'h2);
         end
      join
      rd(ISF_OFF_RAW, 33'h1);
      rd(ISF_OFF_VIEW, 33'h1);
      wr(ISF_OFF_VIEWSEL, 32'h1);
      rd(ISF_OFF_VIEW, 33'h0);
      cmp(33'(master_irq), 33'h0);
      wr(ISF_OFF_MASK, 32'h1);
      rd(ISF_OFF_VIEW, 33'h1);
      cmp(33'(master_irq), 33'h1);
      wr(ISF_OFF_RAW, 32'h1);
      rd(ISF_OFF_RAW, 33'h0, 33'h1);
      cmp(33'(master_irq), 33'h0);
      a0 = 7'($urandom);
      a1 = a0 ^ 7'h40;
      wr(ISF_OFF_OWNADDR, {25'h0, a0});
      wr(ISF_OFF_OWNADDR, {23'h0, 1'b1, 1'b0, a1});
      rd(ISF_OFF_OWNADDR, {18'h0, a1, 1'b0, a0});
      frame(a0, 1'b0, 1'b0);
      m.stop();
      wr(ISF_OFF_SCTL, 32'h1);
      d = 8'($urandom);
      frame(a0, 1'b0, 1'b1);
      bw(d, 1'b1);
      m.stop();
      rd(ISF_OFF_SDATA, {25'h0, d});
      frame(a0 ^ 7'h20, 1'b0, 1'b0);
      m.stop();
      frame(a1, 1'b0, 1'b1);
      m.stop();
      d = 8'($urandom);
      wr(ISF_OFF_SDATA, {24'h0, d});
      frame(a0, 1'b1, 1'b1);
      m.rd(1'b1, got);
      m.stop();
      cmp({25'h0, got}, {25'h0, d});
      for (int k = 0; k < 4; k++) begin
         wr(ISF_OFF_ACK, 32'(k));
         frame(a0, 1'b0, k[0] ? k[1] : 1'b1);
         // a refused address would end the frame on a real bus
         if (k != 1) bw(8'($urandom), k[0] ? k[1] : 1'b1);
         m.stop();
      end
      wr(ISF_OFF_ACK, 32'h0);
      for (int k = 0; k < 8; k++) begin
         wr(ISF_OFF_SCTL, 32'(k));
         rd(ISF_OFF_SSTAT, 33'(k), 33'h7);
      end
      rd(ISF_OFF_SCTL, 33'h0);
      wr(ISF_OFF_SCTL, 32'h1);
      wr(ISF_OFF_SCTL, 32'h5);
      for (int t = 1; t <= 8; t++) begin
         wr(ISF_OFF_RXCFG, 32'h108 | 32'(t - 1) | 32'((t & 1) << 4));
         rd(ISF_OFF_RXCFG, 33'h0, 33'hF_0000);
         frame(a0, 1'b0, 1'b1);
         for (int i = 1; i <= t; i++) begin
            d = 8'($urandom);
            if (i == 1) first = d;
            bw(d, 1'b1);
            cmp({31'h0, fifo_req, dma_req}, {31'h0, i == t, i == t && t[0]});
         end
         m.stop();
         rd(ISF_OFF_RXCFG, {13'h0, 4'(t), 11'h0, t[0], 1'b1, 3'(t - 1)}, 33'hF_001F);
         rd(ISF_OFF_RXDATA, {25'h0, first});
      end
      wr(ISF_OFF_RXCFG, 32'h100);
      d = 8'($urandom);
      frame(a0, 1'b0, 1'b1);
      bw(d, 1'b1);
      m.stop();
      rd(ISF_OFF_RXCFG, 33'h0, 33'hF_0000);
      rd(ISF_OFF_SDATA, {25'h0, d});
      tally_and_finish();
   end
endmodule // tb_i2c_slave_fifo_ack_control
`default_nettype wire
